// ---- pmpm_pkg.sv ----
// Purpose: shared constants and types of the program memory partition map
// Assumes: one clock domain, active low asynchronous reset
// Notes:   all numbers of the block live here
package pmpm_pkg;

  localparam int          PC_WIDTH        = 15;
  localparam int          WORD_WIDTH      = 14;
  localparam int          BYTE_WIDTH      = 8;
  localparam int          PTR_WIDTH       = 16;
  localparam int          PTR_PROG_BIT    = 15;
  localparam int          MEM_WORDS_DEF   = 16384;
  localparam logic [14:0] RESET_VECTOR    = 15'h0000;
  localparam logic [14:0] INT_VECTOR      = 15'h0004;
  localparam int          BOOT_MIN_WORDS  = 512;
  localparam logic [2:0]  BOOT_MIN_CODE   = 3'h7;
  localparam int          STORAGE_WORDS   = 128;
  localparam logic        CFG_ERASED      = 1'b1;
  localparam logic [2:0]  BOOT_SIZE_RESET = 3'h7;
  localparam logic        EXEC_STAT_RESET = 1'b1;

  typedef enum logic [1:0] {
    REGION_APP     = 2'b00,
    REGION_BOOT    = 2'b01,
    REGION_STORAGE = 2'b10,
    REGION_CONFIG  = 2'b11
  } pmpm_region_t;

  typedef enum logic [1:0] {
    IND_IDLE = 2'b00,
    IND_READ = 2'b01,
    IND_DONE = 2'b10
  } pmpm_ind_state_t;

endpackage : pmpm_pkg

// ---- pmpm_region_decode.sv ----
// Purpose: classify one address into exactly one memory region
// Assumes: address already wrapped into the implemented space
// Notes:   purely combinational, boundaries follow the live config bits
`timescale 1ns/1ps
module pmpm_region_decode
  import pmpm_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF,
  parameter int ADDR_W    = $clog2(MEM_WORDS)
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              isConfig,
  input  wire logic              bootEnableN,
  input  wire logic              storageEnableN,
  input  wire logic [2:0]        bootSize,
  output pmpm_region_t           region,
  output logic                   execOk
);

  logic [31:0] bootWords;
  logic [31:0] addrWide;
  logic [2:0]  shiftAmt;

  always_comb begin
    shiftAmt  = BOOT_MIN_CODE - bootSize;
    bootWords = 32'(BOOT_MIN_WORDS) << shiftAmt;
    // boot block never larger than half the memory
    if (bootWords > 32'(MEM_WORDS / 2)) begin
      bootWords = 32'(MEM_WORDS / 2);
    end
    addrWide = 32'(addr);
    if (isConfig) begin
      region = REGION_CONFIG;
    end else if (!bootEnableN && addrWide < bootWords) begin
      region = REGION_BOOT;
    end else if (!storageEnableN &&
                 addrWide >= 32'(MEM_WORDS - STORAGE_WORDS)) begin
      region = REGION_STORAGE;
    end else begin
      region = REGION_APP;
    end
    execOk = (region == REGION_APP) || (region == REGION_BOOT);
  end

endmodule : pmpm_region_decode

// ---- pmpm_partition_map.sv ----
// Purpose: program counter, indirect program reads and flash partitioning
// Assumes: all inputs synchronous to clock; memory answers reads in 1 cycle
// Notes:   config bits are latched copies of the nonvolatile words
//
// Overview of operation
// - program counter is fifteen bits, addressing 32K words of 14 bits
// - addresses beyond implemented size wrap into the implemented space
// - fetch starts at 0000h after reset, interrupt entry goes to 0004h
// - pointer high byte bit 7 set makes indirect reads use program memory
// - indirect move to w returns only the low eight bits of the word
// - indirect writes aimed at program memory change nothing
// - indirect program memory reads take one extra instruction cycle
// - return with literal returns and loads its constant into w
// - both enable bits at 1 make all user flash application block
// - enabled boot block spans 0000h to size end, application follows
// - storage enable at 0 reserves last 128 words as storage area
// - storage area addresses are not valid for execution
// - write to protected location leaves memory and sets write error
// - application, boot and config areas each have own protect bit
// - executing outside valid area gives violation reset, clears status
// - boot enabled at 0, code 111 is 512 words, capped at half memory
// - write protection once set persists until bulk erase or reset
// - boot size changes only while boot disabled, by bulk erase or by reset
`timescale 1ns/1ps
module pmpm_partition_map
  import pmpm_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF,
  parameter int ADDR_W    = $clog2(MEM_WORDS)
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  cfgWrite,
  input  wire logic                  cfgBootEnableN,
  input  wire logic                  cfgStorageEnableN,
  input  wire logic [2:0]            cfgBootSize,
  input  wire logic                  cfgAppProtectN,
  input  wire logic                  cfgBootProtectN,
  input  wire logic                  cfgConfigProtectN,
  input  wire logic                  bulkErase,
  output logic                       boot_region_enable_n,
  output logic                       storage_region_enable_n,
  output logic [2:0]                 boot_region_size,
  output logic                       app_region_write_protect,
  output logic                       boot_region_write_protect,
  output logic                       config_region_write_protect,
  input  wire logic                  fetchAdvance,
  input  wire logic                  fetchExec,
  input  wire logic                  jumpValid,
  input  wire logic [PC_WIDTH-1:0]   jumpTarget,
  input  wire logic                  intEntry,
  input  wire logic                  retLitValid,
  input  wire logic [PC_WIDTH-1:0]   retAddr,
  input  wire logic [BYTE_WIDTH-1:0] retLitConst,
  output logic [PC_WIDTH-1:0]        pc,
  output logic [ADDR_W-1:0]          fetchPhysAddr,
  output logic                       wLoad,
  output logic [BYTE_WIDTH-1:0]      wData,
  input  wire logic                  execStatusSet,
  output logic                       execViolationReset,
  output logic                       exec_violation_status,
  input  wire logic                  indReq,
  input  wire logic                  indWrite,
  input  wire logic [PTR_WIDTH-1:0]  indPtr,
  output logic                       indToDataMem,
  output logic                       indBusy,
  output logic                       indDone,
  output logic [BYTE_WIDTH-1:0]      indReadData,
  output logic                       indWriteIgnored,
  output logic                       pmReadEn,
  output logic [ADDR_W-1:0]          pmReadAddr,
  input  wire logic [WORD_WIDTH-1:0] pmReadData,
  input  wire logic                  nvWriteReq,
  input  wire logic [PC_WIDTH-1:0]   nvWriteAddr,
  input  wire logic                  nvWriteConfig,
  input  wire logic                  nvErrClear,
  output logic                       nvWriteGrant,
  output logic                       nv_write_error_flag
);

  pmpm_region_t    fetchRegion;
  pmpm_region_t    writeRegion;
  logic            fetchExecOk;
  logic            writeProtected;
  logic            violation;
  logic            indProg;
  pmpm_ind_state_t indState;
  pmpm_ind_state_t next_indState;
  logic [ADDR_W-1:0] nvPhysAddr;

  // configuration copies: protection only tightens, erase restores
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      boot_region_enable_n    <= CFG_ERASED;
      storage_region_enable_n <= CFG_ERASED;
      boot_region_size        <= BOOT_SIZE_RESET;
    end else if (bulkErase) begin
      boot_region_enable_n    <= CFG_ERASED;
      storage_region_enable_n <= CFG_ERASED;
      boot_region_size        <= BOOT_SIZE_RESET;
    end else if (cfgWrite) begin
      boot_region_enable_n    <= cfgBootEnableN;
      storage_region_enable_n <= cfgStorageEnableN;
      if (boot_region_enable_n) begin
        boot_region_size <= cfgBootSize;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      app_region_write_protect    <= CFG_ERASED;
      boot_region_write_protect   <= CFG_ERASED;
      config_region_write_protect <= CFG_ERASED;
    end else if (bulkErase) begin
      app_region_write_protect    <= CFG_ERASED;
      boot_region_write_protect   <= CFG_ERASED;
      config_region_write_protect <= CFG_ERASED;
    end else if (cfgWrite) begin
      app_region_write_protect    <= app_region_write_protect &
                                     cfgAppProtectN;
      boot_region_write_protect   <= boot_region_write_protect &
                                     cfgBootProtectN;
      config_region_write_protect <= config_region_write_protect &
                                     cfgConfigProtectN;
    end
  end

  assign fetchPhysAddr = pc[ADDR_W-1:0];
  assign nvPhysAddr    = nvWriteAddr[ADDR_W-1:0];

  pmpm_region_decode #(
    .MEM_WORDS (MEM_WORDS),
    .ADDR_W    (ADDR_W)
  ) fetchDecode (
    .addr           (fetchPhysAddr),
    .isConfig       (1'b0),
    .bootEnableN    (boot_region_enable_n),
    .storageEnableN (storage_region_enable_n),
    .bootSize       (boot_region_size),
    .region         (fetchRegion),
    .execOk         (fetchExecOk)
  );

  pmpm_region_decode #(
    .MEM_WORDS (MEM_WORDS),
    .ADDR_W    (ADDR_W)
  ) writeDecode (
    .addr           (nvPhysAddr),
    .isConfig       (nvWriteConfig),
    .bootEnableN    (boot_region_enable_n),
    .storageEnableN (storage_region_enable_n),
    .bootSize       (boot_region_size),
    .region         (writeRegion),
    .execOk         ()
  );

  // per-region write protection, storage area bit lives outside this block
  always_comb begin
    case (writeRegion)
      REGION_BOOT:    writeProtected = !boot_region_write_protect;
      REGION_CONFIG:  writeProtected = !config_region_write_protect;
      REGION_APP:     writeProtected = !app_region_write_protect;
      default:        writeProtected = 1'b0;
    endcase
  end

  assign nvWriteGrant = nvWriteReq && !writeProtected;

  // write error flag, a new error beats a clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nv_write_error_flag <= 1'b0;
    end else if (nvWriteReq && writeProtected) begin
      nv_write_error_flag <= 1'b1;
    end else if (nvErrClear) begin
      nv_write_error_flag <= 1'b0;
    end
  end

  assign violation = fetchExec && !fetchExecOk;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      execViolationReset <= 1'b0;
    end else begin
      execViolationReset <= violation;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exec_violation_status <= EXEC_STAT_RESET;
    end else if (violation) begin
      exec_violation_status <= 1'b0;
    end else if (execStatusSet) begin
      exec_violation_status <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc <= RESET_VECTOR;
    end else if (violation) begin
      pc <= RESET_VECTOR;
    end else if (intEntry) begin
      pc <= INT_VECTOR;
    end else if (retLitValid) begin
      pc <= retAddr;
    end else if (jumpValid) begin
      pc <= jumpTarget;
    end else if (fetchAdvance) begin
      pc <= PC_WIDTH'(pc + 1'b1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wLoad <= 1'b0;
      wData <= '0;
    end else if (retLitValid && !violation && !intEntry) begin
      wLoad <= 1'b1;
      wData <= retLitConst;
    end else if (indState == IND_READ) begin
      wLoad <= 1'b1;
      wData <= pmReadData[BYTE_WIDTH-1:0];
    end else begin
      wLoad <= 1'b0;
    end
  end

  assign indProg      = indPtr[PTR_PROG_BIT];
  assign indToDataMem = indReq && !indProg && indState == IND_IDLE;
  assign indBusy      = indState == IND_READ;

  always_comb begin
    case (indState)
      IND_IDLE: begin
        if (indReq && indProg && !indWrite) begin
          next_indState = IND_READ;
        end else begin
          next_indState = IND_IDLE;
        end
      end
      IND_READ: next_indState = IND_DONE;
      IND_DONE: next_indState = IND_IDLE;
      default:  next_indState = IND_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      indState <= IND_IDLE;
    end else begin
      indState <= next_indState;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pmReadEn   <= 1'b0;
      pmReadAddr <= '0;
    end else if (indState == IND_IDLE && indReq && indProg && !indWrite) begin
      pmReadEn   <= 1'b1;
      pmReadAddr <= indPtr[ADDR_W-1:0];
    end else begin
      pmReadEn   <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      indReadData <= '0;
      indDone     <= 1'b0;
    end else if (indState == IND_READ) begin
      indReadData <= pmReadData[BYTE_WIDTH-1:0];
      indDone     <= 1'b1;
    end else begin
      indDone     <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      indWriteIgnored <= 1'b0;
    end else begin
      indWriteIgnored <= indReq && indWrite && indProg;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  addr_wrap_a: assert property (pmReadEn |->
    pmReadAddr == $past(indPtr[ADDR_W-1:0])) else $error("bad read address");
  int_vector_a: assert property (intEntry && !violation |=>
    pc == INT_VECTOR) else $error("interrupt entry missed vector");
  pc_step_a: assert property (fetchAdvance && !violation && !intEntry &&
    !retLitValid && !jumpValid |=> pc == PC_WIDTH'($past(pc) + 1))
    else $error("program counter step wrong");
  ind_latency_a: assert property (indState == IND_IDLE && indReq &&
    indProg && !indWrite |=> indBusy ##1 indDone)
    else $error("indirect read latency wrong");
  ind_low_byte_a: assert property (indBusy |=>
    indReadData == $past(pmReadData[7:0])) else $error("indirect byte wrong");
  ind_no_write_a: assert property (indReq && indWrite && indProg |->
    !indToDataMem ##1 !pmReadEn && indWriteIgnored)
    else $error("program memory write not blocked");
  retlit_w_a: assert property (retLitValid && !violation && !intEntry
    |=> wLoad && wData == $past(retLitConst) && pc == $past(retAddr))
    else $error("return with literal wrong");
  default_app_a: assert property (boot_region_enable_n &&
    storage_region_enable_n && !nvWriteConfig |-> writeRegion == REGION_APP &&
    fetchRegion == REGION_APP) else $error("default map not application");
  boot_min_a: assert property (!boot_region_enable_n &&
    !nvWriteConfig && boot_region_size == BOOT_MIN_CODE &&
    32'(nvPhysAddr) < BOOT_MIN_WORDS |-> writeRegion == REGION_BOOT)
    else $error("smallest boot block wrong");
  storage_exec_a: assert property (!storage_region_enable_n &&
    fetchExec && 32'(fetchPhysAddr) >= 32'(MEM_WORDS - STORAGE_WORDS)
    |=> execViolationReset && pc == RESET_VECTOR)
    else $error("storage area executable");
  violation_a: assert property (violation |=> execViolationReset &&
    !exec_violation_status && pc == RESET_VECTOR)
    else $error("violation reset missing");
  protect_err_a: assert property (nvWriteReq && writeProtected |->
    !nvWriteGrant ##1 nv_write_error_flag) else $error("write not flagged");
  protect_keep_a: assert property (!app_region_write_protect &&
    !bulkErase |=> !app_region_write_protect) else $error("protection lost");
  size_lock_a: assert property (!boot_region_enable_n && !bulkErase |=>
    $stable(boot_region_size)) else $error("boot size changed while enabled");
  ind_read_c: cover property (indReq && indProg && !indWrite ##2 indDone);
  violation_c: cover property (fetchExec && !fetchExecOk);
  protect_c: cover property (nvWriteReq && writeProtected);
  boot_c: cover property (fetchExec && fetchRegion == REGION_BOOT);

endmodule : pmpm_partition_map

// ---- pmpm_flash_model.sv ----
// Purpose: program flash array seen from the indirect read port
// Assumes: word is valid while pmReadEn is high
// Notes:   outside a read the data lines toggle every cycle
`timescale 1ns/1ps
module pmpm_flash_model
  import pmpm_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  pmReadEn,
  input  wire logic [13:0]           pmReadAddr,
  output logic      [WORD_WIDTH-1:0] pmReadData
);
  logic junk = 1'b0;

  // idle pattern so a late sample never sees the word
  always @(posedge clock) junk <= ~junk;

  // contents: an address-derived pattern
  always_comb begin
    if (pmReadEn)
      pmReadData = {pmReadAddr[5:0], pmReadAddr[7:0]} ^ 14'h2a55;
    else
      pmReadData = junk ? 14'h3fff : 14'h0000;
  end
endmodule : pmpm_flash_model

// ---- tb.sv ----
// Purpose: self-checking bench of the partition map
// Assumes: default memory size of 16384 words
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb
  import pmpm_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0;
  logic cfgWrite = 1'b0, cfgBootEnableN = 1'b1, cfgStorageEnableN = 1'b1;
  logic cfgAppProtectN = 1'b1, cfgBootProtectN = 1'b1;
  logic cfgConfigProtectN = 1'b1, bulkErase = 1'b0;
  logic [2:0] cfgBootSize = 3'h7;
  logic fetchAdvance = 1'b0, fetchExec = 1'b0, jumpValid = 1'b0;
  logic intEntry = 1'b0, retLitValid = 1'b0, execStatusSet = 1'b0;
  logic [14:0] jumpTarget = 15'h0000, retAddr = 15'h0000;
  logic [7:0] retLitConst = 8'h00;
  logic indReq = 1'b0, indWrite = 1'b0, nvWriteReq = 1'b0;
  logic nvWriteConfig = 1'b0, nvErrClear = 1'b0;
  logic [15:0] indPtr = 16'h0000;
  logic [14:0] nvWriteAddr = 15'h0000;
  logic boot_region_enable_n, storage_region_enable_n;
  logic app_region_write_protect, boot_region_write_protect;
  logic config_region_write_protect, wLoad, execViolationReset;
  logic exec_violation_status, indToDataMem, indBusy, indDone;
  logic indWriteIgnored, pmReadEn, nvWriteGrant, nv_write_error_flag;
  logic [2:0] boot_region_size;
  logic [14:0] pc;
  logic [13:0] fetchPhysAddr, pmReadAddr, pmReadData;
  logic [7:0] wData, indReadData;
  int mismatches = 0, num_checks = 0, cycles = 0;

  pmpm_partition_map u_pmpm_partition_map (.clock, .rstn, .cfgWrite,
    .cfgBootEnableN, .cfgStorageEnableN, .cfgBootSize, .cfgAppProtectN,
    .cfgBootProtectN, .cfgConfigProtectN, .bulkErase, .boot_region_enable_n,
    .storage_region_enable_n, .boot_region_size, .app_region_write_protect,
    .boot_region_write_protect, .config_region_write_protect, .fetchAdvance,
    .fetchExec, .jumpValid, .jumpTarget, .intEntry, .retLitValid, .retAddr,
    .retLitConst, .pc, .fetchPhysAddr, .wLoad, .wData, .execStatusSet,
    .execViolationReset, .exec_violation_status, .indReq, .indWrite,
    .indPtr, .indToDataMem, .indBusy, .indDone, .indReadData,
    .indWriteIgnored, .pmReadEn, .pmReadAddr, .pmReadData, .nvWriteReq,
    .nvWriteAddr, .nvWriteConfig, .nvErrClear, .nvWriteGrant,
    .nv_write_error_flag);

  pmpm_flash_model u_pmpm_flash_model (.clock, .pmReadEn, .pmReadAddr,
    .pmReadData);

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic cfg(input logic en, sa, input logic [2:0] sz,
                     input logic ap, bp, cp);
    {cfgBootEnableN, cfgStorageEnableN, cfgBootSize} = {en, sa, sz};
    {cfgAppProtectN, cfgBootProtectN, cfgConfigProtectN} = {ap, bp, cp};
    cfgWrite = 1'b1;
    tick();
    cfgWrite = 1'b0;
    tick();
  endtask : cfg

  task automatic erase;
    bulkErase = 1'b1;
    tick();
    bulkErase = 1'b0;
    tick();
  endtask : erase

  task automatic nv(input logic [14:0] a, input logic c, input logic ok);
    {nvWriteReq, nvWriteAddr, nvWriteConfig} = {1'b1, a, c};
    #1 check(nvWriteGrant, ok);
    tick();
    check(nv_write_error_flag, !ok);
    nvWriteReq = 1'b0;
    nvErrClear = 1'b1;
    tick();
    nvErrClear = 1'b0;
    tick();
  endtask : nv

  task automatic jump(input logic [14:0] t);
    {jumpValid, jumpTarget} = {1'b1, t};
    tick();
    jumpValid = 1'b0;
    tick();
  endtask : jump

  task automatic test_reset;
    check(pc, 15'h0000);
    check({boot_region_enable_n, storage_region_enable_n}, 2'h3);
    check(boot_region_size, 3'h7);
    check({app_region_write_protect, boot_region_write_protect,
           config_region_write_protect}, 3'h7);
    check({exec_violation_status, nv_write_error_flag}, 2'h2);
    nv(15'h3ff0, 1'b0, 1'b1);
  endtask : test_reset

  task automatic test_pc;
    jump(15'h7ffe);
    check(fetchPhysAddr, 14'h3ffe);
    fetchAdvance = 1'b1;
    tick();
    check(pc, 15'h7fff);
    tick();
    check(pc, 15'h0000);
    fetchAdvance = 1'b0;
    intEntry = 1'b1;
    tick();
    check(pc, 15'h0004);
    intEntry = 1'b0;
    {retLitValid, retAddr, retLitConst} = {1'b1, 15'h1234, 8'ha5};
    tick();
    check({pc, wLoad, wData}, {15'h1234, 1'b1, 8'ha5});
    retLitValid = 1'b0;
    tick();
    check(wLoad, 1'b0);
  endtask : test_pc

  task automatic test_indirect;
    logic [13:0] w;
    w = {6'h23, 8'h23} ^ 14'h2a55;
    {indReq, indPtr} = {1'b1, 16'h8123};
    #1 check(indToDataMem, 1'b0);
    tick();
    indReq = 1'b0;
    check({pmReadEn, indBusy, pmReadAddr}, {2'h3, 14'h0123});
    tick();
    check({indDone, indReadData, wLoad, wData}, {1'b1, w[7:0],
          1'b1, w[7:0]});
    tick();
    {indReq, indPtr} = {1'b1, 16'h0123};
    #1 check(indToDataMem, 1'b1);
    tick();
    {indWrite, indPtr} = {1'b1, 16'h8040};
    tick();
    {indReq, indWrite} = 2'h0;
    check({indWriteIgnored, pmReadEn}, 2'h2);
    tick();
  endtask : test_indirect

  task automatic test_partition;
    cfg(1'b0, 1'b0, 3'h7, 1'b0, 1'b1, 1'b0);
    nv(15'h01ff, 1'b0, 1'b1);
    nv(15'h0200, 1'b0, 1'b0);
    nv(15'h3f7f, 1'b0, 1'b0);
    nv(15'h3f80, 1'b0, 1'b1);
    nv(15'h0010, 1'b1, 1'b0);
    cfg(1'b0, 1'b0, 3'h4, 1'b1, 1'b1, 1'b1);
    check(boot_region_size, 3'h7);
    check({app_region_write_protect, config_region_write_protect},
          2'h0);
    erase();
    check({boot_region_size, app_region_write_protect}, 4'hf);
    cfg(1'b0, 1'b1, 3'h0, 1'b1, 1'b0, 1'b1);
    nv(15'h1fff, 1'b0, 1'b0);
    nv(15'h2000, 1'b0, 1'b1);
    nv(15'h7fff, 1'b0, 1'b1);
    erase();
  endtask : test_partition

  task automatic test_reset_mid;
    cfg(1'b0, 1'b0, 3'h5, 1'b0, 1'b0, 1'b0);
    jump(15'h0123);
    fetchExec = 1'b1;
    tick();
    fetchExec = 1'b0;
    check({execViolationReset, pc}, {1'b0, 15'h0123});
    rstn = 1'b0;
    tick();
    check({pc, boot_region_enable_n, storage_region_enable_n,
           boot_region_size}, {15'h0000, 2'h3, 3'h7});
    check({app_region_write_protect, boot_region_write_protect,
           config_region_write_protect, exec_violation_status}, 4'hf);
    rstn = 1'b1;
    tick();
    check({pc, wLoad, nv_write_error_flag}, {15'h0000, 2'h0});
  endtask : test_reset_mid

  task automatic test_violation;
    cfg(1'b1, 1'b0, 3'h7, 1'b1, 1'b1, 1'b1);
    jump(15'h3f7f);
    fetchExec = 1'b1;
    tick();
    check(execViolationReset, 1'b0);
    fetchExec = 1'b0;
    jump(15'h3f80);
    fetchExec = 1'b1;
    tick();
    fetchExec = 1'b0;
    check({execViolationReset, exec_violation_status, pc},
          {2'h2, 15'h0000});
    tick();
    execStatusSet = 1'b1;
    tick();
    execStatusSet = 1'b0;
    check({execViolationReset, exec_violation_status}, 2'h1);
    erase();
  endtask : test_violation

  initial begin
    repeat (12) @(posedge clock);
    #1 rstn = 1'b1;
    tick();
    test_reset();
    test_pc();
    test_indirect();
    test_partition();
    test_reset_mid();
    test_violation();
    finish_test();
  end
endmodule : tb
